/* hw/fpd_pkg.sv */
// Shared constants, register map and carrier types for the packet DMA scheduler
package fpd_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int FIFO_W   = 36;
	localparam int DATA_W   = 32;
	localparam int MEM_AW   = 8;
	localparam int WS_DEPTH = 4;
	localparam int CNT_W    = 16;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_PKT       = 8'h04;
	localparam logic [7:0] REG_WR_SUBMIT = 8'h08;
	localparam logic [7:0] REG_RD_DEST   = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam logic [7:0] REG_MEM_ADDR  = 8'h14;
	localparam logic [7:0] REG_MEM_DATA  = 8'h18;
	localparam logic [7:0] REG_MBOX_TX   = 8'h1C;
	localparam logic [7:0] REG_MBOX_RX   = 8'h20;
	localparam logic [7:0] REG_DONE_CNT  = 8'h24;

	// Control fields
	localparam int CTRL_VAR    = 0;
	localparam int CTRL_PACE   = 1;
	localparam int CTRL_SRCDEC = 3;
	localparam int CTRL_DSTDEC = 4;
	localparam int CTRL_AE_EN  = 5;

	// Status fields
	localparam int ST_BUSY    = 0;
	localparam int ST_RS_VAL  = 1;
	localparam int ST_AE_EN   = 2;
	localparam int ST_PEND    = 3;
	localparam int ST_MAIL    = 5;
	localparam int ST_MBRX    = 6;
	localparam int ST_WS_FULL = 7;
	localparam int ST_DIR_RD  = 8;
	localparam int ST_CNT     = 16;

	localparam logic [15:0] PKT_RESET   = 16'h0080;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PACE_NONE, PACE_SRC, PACE_DST, PACE_BOTH} fpd_pace_e;
	typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DONE} fpd_state_e;

	typedef struct packed {
		logic port_a_low_fill_flag;
		logic port_a_low_space_flag;
		logic input_space_flag;
		logic out_ready_flag;
		logic mail_waiting_n;
	} fpd_flags_s;

	typedef struct packed {
		logic write_en;
		logic read_en;
		logic mbox_sel;
		logic data_oe;
	} fpd_ctl_s;

	function automatic logic [31:0] fpd_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		end
		return res;
	endfunction

endpackage

/* hw/fpd_sched.sv */
// Packet DMA scheduler driving one port of a bidirectional clocked FIFO
`timescale 1ns/100ps
`default_nettype none

module fpd_sched
	import fpd_pkg::*;
#(
	parameter int MEM_AW_P   = fpd_pkg::MEM_AW,
	parameter int WS_DEPTH_P = fpd_pkg::WS_DEPTH,
	parameter int CNT_W_P    = fpd_pkg::CNT_W
)(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire fpd_pkg::fpd_flags_s    fifo_flags,
	output fpd_pkg::fpd_ctl_s           fifo_ctl,
	input  wire logic [FIFO_W-1:0]      fifo_data_i,
	output logic [FIFO_W-1:0]           fifo_data_o
);
	import fpd_pkg::*;

	localparam int WS_PW = (WS_DEPTH_P > 1) ? $clog2(WS_DEPTH_P) : 1;
	localparam logic [CNT_W_P-1:0] CNT_ONE = CNT_W_P'(1);
	localparam logic [WS_PW-1:0]   WS_LAST = WS_PW'(WS_DEPTH_P - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fpd_state_e             st_q, st_d;
	logic                   var_q, src_dec_q, dst_dec_q, ae_en_q;
	logic [1:0]             pace_q;
	logic [CNT_W_P-1:0]     pkt_q, dma_transfer_count_q, done_cnt_q;
	logic [MEM_AW_P-1:0]    rd_dest_q, mem_ptr_q, mem_ptr_d, mem_addr_q, rs_addr_q;
	logic                   dir_rd_q, rs_valid_q;
	logic [MEM_AW_P-1:0]    ws_mem [WS_DEPTH_P];
	logic [WS_PW-1:0]       ws_head_q, ws_tail_q, ws_tail_nx, ws_head_nx;
	logic [1:0]             pend_q, flag_prev_q;
	logic                   mb_tx_pend_q, data_is_mb_q, mb_rx_valid_q;
	logic [DATA_W-1:0]      mb_tx_q, mb_rx_q;
	logic [DATA_W-1:0]      mem [2**MEM_AW_P];
	logic [FIFO_W-1:0]      data_o_q;
	logic                   bvalid_q, rvalid_q;
	logic [1:0]             bresp_q, rresp_q;
	logic [31:0]            rdata_q;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic dma_mem_wr;
	wire logic wr_take   = s_axi_awvalid & s_axi_wvalid & ~bvalid_q & ~dma_mem_wr;
	wire logic rd_take   = s_axi_arvalid & ~rvalid_q;
	wire logic w_ctrl    = wr_take & (s_axi_awaddr == REG_CTRL);
	wire logic w_pkt     = wr_take & (s_axi_awaddr == REG_PKT);
	wire logic w_submit  = wr_take & (s_axi_awaddr == REG_WR_SUBMIT);
	wire logic w_rdest   = wr_take & (s_axi_awaddr == REG_RD_DEST);
	wire logic w_maddr   = wr_take & (s_axi_awaddr == REG_MEM_ADDR);
	wire logic w_mdata   = wr_take & (s_axi_awaddr == REG_MEM_DATA);
	wire logic w_mbtx    = wr_take & (s_axi_awaddr == REG_MBOX_TX);
	wire logic w_known   = w_ctrl | w_pkt | w_submit | w_rdest | w_maddr | w_mdata | w_mbtx;
	wire logic r_mdata   = rd_take & (s_axi_araddr == REG_MEM_DATA);
	wire logic r_mbrx    = rd_take & (s_axi_araddr == REG_MBOX_RX);
	wire logic [31:0] wmerge_ctrl = fpd_merge({26'h0, ae_en_q, dst_dec_q, src_dec_q, pace_q,
		var_q}, s_axi_wdata, s_axi_wstrb);
	wire logic [31:0] wmerge_pkt  = fpd_merge(32'(pkt_q), s_axi_wdata, s_axi_wstrb);
	wire logic [31:0] wmerge_mem  = fpd_merge(mem[mem_addr_q], s_axi_wdata, s_axi_wstrb);

	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = rd_take;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	wire fpd_pace_e pace   = fpd_pace_e'(pace_q);
	wire logic idle        = (st_q == ST_IDLE);
	wire logic xfer        = (st_q == ST_XFER);
	wire logic done        = (st_q == ST_DONE);
	// Fixed packets run unpaced; the flags already guarantee a whole packet
	wire logic paced       = var_q & (dir_rd_q ? (pace == PACE_SRC || pace == PACE_BOTH)
		: (pace == PACE_DST || pace == PACE_BOTH));
	wire logic pace_ok     = ~paced | (dir_rd_q ? fifo_flags.out_ready_flag
		: fifo_flags.input_space_flag);
	// Wait state whenever the FIFO cannot serve, paced or not
	wire logic bus_rdy     = dir_rd_q ? fifo_flags.out_ready_flag
		: fifo_flags.input_space_flag;
	wire logic fire        = xfer & pace_ok & bus_rdy;
	assign dma_mem_wr      = fire & dir_rd_q;

	// Mailbox cycles are only issued between blocks
	wire logic mb_rx_go    = idle & ~fifo_flags.mail_waiting_n & ~mb_rx_valid_q;
	wire logic mb_tx_go    = idle & mb_tx_pend_q & data_is_mb_q & ~mb_rx_go;
	wire logic idle_free   = idle & ~mb_rx_go & ~mb_tx_pend_q;

	wire logic ws_empty    = (ws_head_q == ws_tail_q);
	assign ws_tail_nx      = (ws_tail_q == WS_LAST) ? '0 : ws_tail_q + 1'b1;
	assign ws_head_nx      = (ws_head_q == WS_LAST) ? '0 : ws_head_q + 1'b1;
	wire logic ws_full     = (ws_tail_nx == ws_head_q);

	wire logic fill        = fifo_flags.port_a_low_fill_flag;
	wire logic space       = fifo_flags.port_a_low_space_flag;
	wire logic ae_take     = fill & ae_en_q & (idle_free | xfer);
	wire logic rd_start_ae = ae_take & idle_free;
	wire logic rs_push     = ae_take & xfer & ~rs_valid_q;
	wire logic wr_direct   = w_submit & idle_free & ~rd_start_ae & space & ws_empty;
	wire logic ws_append   = w_submit & ~wr_direct & ~ws_full;
	wire logic ws_idle_go  = idle_free & ~rd_start_ae & ~ws_empty & space;

	wire logic dn_rs       = done & rs_valid_q;
	wire logic dn_fill     = done & ~rs_valid_q & fill;
	wire logic dn_ws       = done & ~rs_valid_q & ~fill & ~ws_empty & space;
	wire logic reen        = done & ~rs_valid_q & ~fill & ~dn_ws;

	wire logic start_rd    = rd_start_ae | dn_rs | dn_fill;
	wire logic start_wr    = wr_direct | ws_idle_go | dn_ws;
	wire logic start_any   = start_rd | start_wr;
	wire logic ws_pop      = ws_idle_go | dn_ws;
	wire logic use_rdest   = rd_start_ae | dn_fill;
	wire logic step_dec    = dir_rd_q ? dst_dec_q : src_dec_q;
	wire logic last_xfer   = fire & (dma_transfer_count_q <= CNT_ONE);
	wire logic [MEM_AW_P-1:0] start_addr = dn_rs ? rs_addr_q : use_rdest ? rd_dest_q
		: wr_direct ? s_axi_wdata[MEM_AW_P-1:0] : ws_mem[ws_head_q];
	wire logic [1:0] flag_now = {space, fill};
	wire logic [1:0] pend_set = flag_now & ~flag_prev_q;

	always_comb
	begin
		mem_ptr_d = mem_ptr_q;
		if (start_any)
			mem_ptr_d = start_addr;
		else if (fire)
			mem_ptr_d = step_dec ? mem_ptr_q - 1'b1 : mem_ptr_q + 1'b1;
	end

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: if (start_any) st_d = ST_XFER;
			ST_XFER: if (last_xfer) st_d = ST_DONE;
			ST_DONE: st_d = start_any ? ST_XFER : ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// FIFO side address never moves, so only strobes and data reach the pins
	assign fifo_ctl.write_en = (fire & ~dir_rd_q) | mb_tx_go;
	assign fifo_ctl.read_en  = dma_mem_wr | mb_rx_go;
	assign fifo_ctl.mbox_sel = mb_tx_go | mb_rx_go;
	assign fifo_ctl.data_oe  = (xfer & ~dir_rd_q) | (idle & mb_tx_pend_q);
	assign fifo_data_o       = data_o_q;

	// ----------------------------------------------------------------
	// Engine registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q     <= ST_IDLE;
			dma_transfer_count_q <= '0;
			dir_rd_q <= 1'b0;
			ae_en_q  <= 1'b1;
			pend_q   <= '0;
		end
		else
		begin
			st_q <= st_d;
			if (start_any)
				dma_transfer_count_q <= pkt_q;
			else if (fire)
				dma_transfer_count_q <= dma_transfer_count_q - CNT_ONE;
			if (start_rd)
				dir_rd_q <= 1'b1;
			else if (start_wr)
				dir_rd_q <= 1'b0;
			if (reen || (w_ctrl && s_axi_wdata[CTRL_AE_EN] && s_axi_wstrb[0]))
				ae_en_q <= 1'b1;
			else if (ae_take)
				ae_en_q <= 1'b0;
			// Fresh flag edge beats the handler clear
			pend_q <= (done ? 2'b00 : pend_q) | pend_set;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mem_ptr_q   <= '0;
			rs_valid_q  <= 1'b0;
			rs_addr_q   <= '0;
			ws_head_q   <= '0;
			ws_tail_q   <= '0;
			// Track the pins in reset so an idle-high flag shows no false edge
			flag_prev_q <= flag_now;
			done_cnt_q  <= '0;
		end
		else
		begin
			mem_ptr_q   <= mem_ptr_d;
			flag_prev_q <= flag_now;
			if (rs_push)
			begin
				rs_valid_q <= 1'b1;
				rs_addr_q  <= rd_dest_q;
			end
			else if (dn_rs)
				rs_valid_q <= 1'b0;
			if (ws_append)
				ws_tail_q <= ws_tail_nx;
			if (ws_pop)
				ws_head_q <= ws_head_nx;
			if (last_xfer)
				done_cnt_q <= done_cnt_q + CNT_ONE;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (ws_append)
			ws_mem[ws_tail_q] <= s_axi_wdata[MEM_AW_P-1:0];
		if (dma_mem_wr)
			mem[mem_ptr_q] <= fifo_data_i[DATA_W-1:0];
		else if (w_mdata)
			mem[mem_addr_q] <= wmerge_mem;
		data_o_q <= (idle && mb_tx_pend_q) ? FIFO_W'(mb_tx_q) : FIFO_W'(mem[mem_ptr_d]);
	end

	// ----------------------------------------------------------------
	// Software registers and mailbox
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			var_q         <= 1'b0;
			pace_q        <= '0;
			src_dec_q     <= 1'b0;
			dst_dec_q     <= 1'b0;
			pkt_q         <= CNT_W_P'(PKT_RESET);
			rd_dest_q     <= '0;
			mem_addr_q    <= '0;
			mb_tx_q       <= '0;
			mb_tx_pend_q  <= 1'b0;
			data_is_mb_q  <= 1'b0;
			mb_rx_q       <= '0;
			mb_rx_valid_q <= 1'b0;
		end
		else
		begin
			if (w_ctrl)
			begin
				var_q     <= wmerge_ctrl[CTRL_VAR];
				pace_q    <= wmerge_ctrl[CTRL_PACE +: 2];
				src_dec_q <= wmerge_ctrl[CTRL_SRCDEC];
				dst_dec_q <= wmerge_ctrl[CTRL_DSTDEC];
			end
			if (w_pkt)
				pkt_q <= wmerge_pkt[CNT_W_P-1:0];
			if (w_rdest)
				rd_dest_q <= s_axi_wdata[MEM_AW_P-1:0];
			else if (use_rdest)
				rd_dest_q <= rd_dest_q + MEM_AW_P'(pkt_q);
			if (w_maddr)
				mem_addr_q <= s_axi_wdata[MEM_AW_P-1:0];
			else
				mem_addr_q <= mem_addr_q + MEM_AW_P'(w_mdata) + MEM_AW_P'(r_mdata);
			if (w_mbtx)
				mb_tx_q <= fpd_merge(mb_tx_q, s_axi_wdata, s_axi_wstrb);
			mb_tx_pend_q <= w_mbtx | (mb_tx_pend_q & ~mb_tx_go);
			data_is_mb_q <= idle & mb_tx_pend_q & ~mb_tx_go;
			if (mb_rx_go)
				mb_rx_q <= fifo_data_i[DATA_W-1:0];
			mb_rx_valid_q <= mb_rx_go | (mb_rx_valid_q & ~r_mbrx);
		end
	end

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	logic [31:0] status_w, rmux_w;
	logic        rhit_w;

	always_comb
	begin
		status_w = '0;
		status_w[ST_BUSY]          = ~idle;
		status_w[ST_RS_VAL]        = rs_valid_q;
		status_w[ST_AE_EN]         = ae_en_q;
		status_w[ST_PEND +: 2]     = pend_q;
		status_w[ST_MAIL]          = fifo_flags.mail_waiting_n;
		status_w[ST_MBRX]          = mb_rx_valid_q;
		status_w[ST_WS_FULL]       = ws_full;
		status_w[ST_DIR_RD]        = dir_rd_q;
		status_w[ST_CNT +: 16]     = 16'(dma_transfer_count_q);
		rhit_w = 1'b1;
		case (s_axi_araddr)
			REG_CTRL:     rmux_w = {26'h0, ae_en_q, dst_dec_q, src_dec_q, pace_q, var_q};
			REG_PKT:      rmux_w = 32'(pkt_q);
			REG_RD_DEST:  rmux_w = 32'(rd_dest_q);
			REG_STATUS:   rmux_w = status_w;
			REG_MEM_ADDR: rmux_w = 32'(mem_addr_q);
			REG_MEM_DATA: rmux_w = mem[mem_addr_q];
			REG_MBOX_TX:  rmux_w = mb_tx_q;
			REG_MBOX_RX:  rmux_w = mb_rx_q;
			REG_DONE_CNT: rmux_w = 32'(done_cnt_q);
			default:
			begin
				rmux_w = '0;
				rhit_w = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end
		else
		begin
			if (wr_take)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= w_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
			if (rd_take)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rmux_w;
				rresp_q  <= rhit_w ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
		fire && dma_transfer_count_q > CNT_ONE |=> dma_transfer_count_q == $past(dma_transfer_count_q) - CNT_ONE)
		else $error("transfer count did not drop by one");
	a_halt_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		last_xfer |=> done && !fifo_ctl.write_en && !fifo_ctl.read_en)
		else $error("transfers continued after count reached zero");
	a_no_empty_rd: assert property (@(posedge aclk) disable iff (!aresetn)
		fifo_ctl.read_en && !fifo_ctl.mbox_sel |-> fifo_flags.out_ready_flag)
		else $error("read issued while FIFO not ready");
	a_no_full_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		fifo_ctl.write_en && !fifo_ctl.mbox_sel |-> fifo_flags.input_space_flag)
		else $error("write issued while FIFO had no space");
	a_addr_step: assert property (@(posedge aclk) disable iff (!aresetn)
		fire && !last_xfer |=> mem_ptr_q == ($past(step_dec) ? $past(mem_ptr_q) - 1'b1
			: $past(mem_ptr_q) + 1'b1))
		else $error("memory address did not step");
	a_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
		ae_take && !reen && !w_ctrl |=> !ae_en_q)
		else $error("fill interrupt stayed enabled after handler entry");
	a_read_first: assert property (@(posedge aclk) disable iff (!aresetn)
		dn_rs |=> xfer && dir_rd_q && !rs_valid_q && mem_ptr_q == $past(rs_addr_q))
		else $error("scheduled read not served first");
	a_pend_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		done && pend_set == 2'b00 |=> pend_q == 2'b00)
		else $error("pending flag bits not cleared by handler");
	a_ws_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		ws_append && ws_tail_q == WS_LAST |=> ws_tail_q == '0)
		else $error("write queue pointer did not wrap");
	a_irq_back: assert property (@(posedge aclk) disable iff (!aresetn)
		reen |=> ae_en_q ##1 (ae_en_q || $past(ae_take)))
		else $error("fill interrupt not re-enabled when idle");
	a_defer_read: assert property (@(posedge aclk) disable iff (!aresetn)
		rs_push |=> rs_valid_q && rs_addr_q == $past(rd_dest_q))
		else $error("busy read not recorded in schedule");

endmodule

`default_nettype wire

/* tb/fpd_fifo_model.sv */
// Behavioural model of the clocked FIFO port that faces the scheduler
`timescale 1ns/100ps
`default_nettype none

module fpd_fifo_model
	import fpd_pkg::*;
#(
	parameter int DEPTH  = 12,
	parameter int AE_OFF = 3,
	parameter int AF_OFF = 3
)(
	input  wire logic              aclk,
	input  wire logic              stall,
	input  wire fpd_pkg::fpd_ctl_s ctl,
	input  wire logic [FIFO_W-1:0] din,
	output fpd_pkg::fpd_flags_s    flags,
	output logic [FIFO_W-1:0]      dout
);
	logic [FIFO_W-1:0] rx_q[$];
	logic [FIFO_W-1:0] tx_q[$];
	logic [FIFO_W-1:0] mail_rx;
	logic [FIFO_W-1:0] mail_tx;
	logic [FIFO_W-1:0] rx_head;
	logic              mail_full;
	int                n_mail_tx;

	// Mailbox path bypasses the queue entirely
	assign dout = ctl.mbox_sel ? mail_rx : rx_head;

	initial
	begin
		flags = 5'h01;
		rx_head = '0;
		mail_rx = '0;
		mail_tx = '0;
		mail_full = 1'b0;
		n_mail_tx = 0;
	end

	always @(posedge aclk)
	begin
		if (ctl.write_en && ctl.mbox_sel)
		begin
			mail_tx = din;
			n_mail_tx++;
		end
		// Writes without space are lost, as on the real part
		else if (ctl.write_en && flags.input_space_flag)
			tx_q.push_back(din);
		if (ctl.read_en && ctl.mbox_sel)
		begin
			// Released word shows inverted stale data
			mail_rx <= ~mail_rx;
			mail_full = 1'b0;
		end
		else if (ctl.read_en && flags.out_ready_flag)
			void'(rx_q.pop_front());
		flags.port_a_low_fill_flag <= rx_q.size() > AE_OFF;
		flags.port_a_low_space_flag <= DEPTH - tx_q.size() > AF_OFF;
		flags.input_space_flag <= tx_q.size() < DEPTH && !stall;
		flags.out_ready_flag <= rx_q.size() != 0 && !stall;
		flags.mail_waiting_n <= !mail_full;
		rx_head <= rx_q.size() != 0 ? rx_q[0] : ~rx_head;
	end
endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the packet DMA scheduler
`timescale 1ns/100ps
`default_nettype none

module tb;
	import fpd_pkg::*;
	localparam int P = 4;
	logic              aclk    = 1'b0;
	logic              aresetn = 1'b0;
	logic [7:0]        awaddr  = 8'h00;
	logic [7:0]        araddr  = 8'h00;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	logic              stall   = 1'b0;
	logic [3:0]        wstrb   = 4'hF;
	logic [31:0]       wdata   = 32'h0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [31:0]       rdata, rd_v, mv, sr;
	logic [1:0]        bresp, rresp, resp;
	fpd_flags_s        flags;
	fpd_ctl_s          ctl;
	logic [FIFO_W-1:0] f_in, f_out;
	logic [31:0]       rs = 32'h4AB23304;
	logic [31:0]       ref_mem[256];
	int                miscompares = 0;
	int                n_checks = 0;
	int                cyc = 0;

	always #2 aclk = ~aclk;

	fpd_sched i_fpd_sched (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fifo_flags(flags), .fifo_ctl(ctl),
		.fifo_data_i(f_in), .fifo_data_o(f_out));

	fpd_fifo_model i_fpd_fifo_model (.aclk(aclk), .stall(stall), .ctl(ctl),
		.din(f_out), .flags(flags), .dout(f_in));

	function automatic logic [31:0] nxt();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Random far-side stalls, drawn fresh each cycle, force wait states at random points in the blocks
	always @(posedge aclk)
	begin
		sr = nxt();
		stall <= sr[0];
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ra, rw, rb;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		rb = 1'b0;
		while (!rb)
		begin
			@(negedge aclk);
			ra = awready;
			rw = wready;
			rb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ra)
				awvalid <= 1'b0;
			if (rw)
				wvalid <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic ra, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rv = 1'b0;
		while (!rv)
		begin
			@(negedge aclk);
			ra = arready;
			rv = rvalid;
			rd_v = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ra)
				arvalid <= 1'b0;
		end
	endtask

	task automatic wait_cnt(input logic [31:0] n);
		rd(REG_DONE_CNT);
		for (int i = 0; i < 400 && rd_v !== n; i++)
			rd(REG_DONE_CNT);
		chk(rd_v, n);
	endtask

	task automatic chk_tx(input int a, input int s, input int left);
		for (int i = 0; i < P; i++)
			chk(i_fpd_fifo_model.tx_q.pop_front(), {4'h0, ref_mem[a + s * i]});
		chk(i_fpd_fifo_model.tx_q.size(), left);
	endtask

	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(REG_CTRL);
		chk(rd_v, 32'h1 << CTRL_AE_EN);
		rd(REG_PKT);
		chk(rd_v, {16'h0, PKT_RESET});
		rd(8'h28);
		chk({rd_v, resp}, {32'h0, RESP_SLVERR});
		wr(REG_STATUS, 32'hFFFFFFFF);
		chk(resp, RESP_SLVERR);
		wr(REG_PKT, P);
		for (int i = 0; i < 16; i++)
		begin
			ref_mem[i] = nxt();
			wr(REG_MEM_ADDR, i);
			wr(REG_MEM_DATA, ref_mem[i]);
		end
		// Second submit arrives while busy and must wait its turn
		wr(REG_WR_SUBMIT, 32'h0);
		wr(REG_WR_SUBMIT, 32'h8);
		wait_cnt(2);
		chk_tx(0, 1, P);
		chk_tx(8, 1, 0);
		wr(REG_CTRL, 32'h1 << CTRL_SRCDEC);
		wr(REG_WR_SUBMIT, 32'h7);
		wait_cnt(3);
		chk_tx(7, -1, 0);
		for (int p = 0; p < 4; p++)
		begin
			wr(REG_CTRL, 32'h1 | (p << CTRL_PACE));
			wr(REG_WR_SUBMIT, 32'h4);
			wait_cnt(4 + p);
			chk_tx(4, 1, 0);
		end
		wr(REG_CTRL, 32'h0);
		// Two packets at once: one by interrupt, one by polling
		wr(REG_RD_DEST, 32'h40);
		@(negedge aclk);
		for (int i = 0; i < 2 * P; i++)
		begin
			ref_mem[64 + i] = nxt();
			i_fpd_fifo_model.rx_q.push_back({4'hA, ref_mem[64 + i]});
		end
		@(posedge aclk);
		wait_cnt(9);
		wr(REG_MEM_ADDR, 32'h40);
		for (int i = 0; i < 2 * P; i++)
		begin
			rd(REG_MEM_DATA);
			chk(rd_v, ref_mem[64 + i]);
		end
		rd(REG_RD_DEST);
		chk(rd_v, 32'h48);
		rd(REG_STATUS);
		chk(rd_v[ST_AE_EN], 1'b1);
		// Packet lands mid write block: read is parked, then served first
		wr(REG_WR_SUBMIT, 32'h4);
		@(negedge aclk);
		for (int i = 0; i < P; i++)
		begin
			ref_mem[72 + i] = nxt();
			i_fpd_fifo_model.rx_q.push_back({4'hA, ref_mem[72 + i]});
		end
		@(posedge aclk);
		wait_cnt(11);
		chk_tx(4, 1, 0);
		for (int i = 0; i < P; i++)
		begin
			rd(REG_MEM_DATA);
			chk(rd_v, ref_mem[72 + i]);
		end
		rd(REG_RD_DEST);
		chk(rd_v, 32'h48);
		rd(REG_STATUS);
		chk(rd_v[ST_RS_VAL], 1'b0);
		mv = nxt();
		@(negedge aclk);
		i_fpd_fifo_model.mail_rx = {4'h5, mv};
		i_fpd_fifo_model.mail_full = 1'b1;
		@(posedge aclk);
		rd_v = 32'h0;
		for (int i = 0; i < 50 && rd_v[ST_MBRX] !== 1'b1; i++)
			rd(REG_STATUS);
		chk(i_fpd_fifo_model.mail_full, 1'b0);
		rd(REG_MBOX_RX);
		chk(rd_v, mv);
		mv = nxt();
		wr(REG_MBOX_TX, mv);
		for (int i = 0; i < 20 && i_fpd_fifo_model.n_mail_tx == 0; i++)
			@(posedge aclk);
		chk(i_fpd_fifo_model.mail_tx, {4'h0, mv});
		report_and_stop();
	end
endmodule

`default_nettype wire
